/* shared/scpm_defs.vh */
// Register offsets, field positions, reset values and timing for the clock and power manager
`ifndef SCPM_DEFS_VH
`define SCPM_DEFS_VH
`define SCPM_ADDR_W        8
`define SCPM_OFF_CTRL      8'h00
`define SCPM_OFF_SLEEP     8'h04
`define SCPM_OFF_CPU_CLOCK_SELECT_REG    8'h08
`define SCPM_OFF_APBASEL   8'h0c
`define SCPM_OFF_APBBSEL   8'h10
`define SCPM_OFF_APBCSEL   8'h14
`define SCPM_OFF_APBAMASK  8'h18
`define SCPM_OFF_APBBMASK  8'h1c
`define SCPM_OFF_APBCMASK  8'h20
`define SCPM_OFF_AHBMASK   8'h24
`define SCPM_OFF_INTENCLR  8'h28
`define SCPM_OFF_IRQ_ENABLE_SET  8'h2c
`define SCPM_OFF_IRQ_FLAG_REG   8'h30
`define SCPM_OFF_RESET_CAUSE_REG    8'h34
`define SCPM_CTRL_CFDEN    0
`define SCPM_CTRL_BKUP     4
`define SCPM_INT_RDY       0
`define SCPM_INT_CFD       1
`define SCPM_RC_POR        0
`define SCPM_RC_BODC       1
`define SCPM_RC_BODI       2
`define SCPM_RC_EXT        4
`define SCPM_RC_WDT        5
`define SCPM_RC_SW         6
`define SCPM_DIV_RST       3'h0
`define SCPM_RC_RST        8'h01
`define SCPM_PRE_BOUND     7'h7f
`define SCPM_PM_MASK_BIT   1
`endif

/* verilog/scpm_sync.v */
// Three-stage input synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module scpm_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire async_i,
  output reg  level_o,
  output reg  rise_o
);
  reg s1;
  reg s2;
  reg s3;

  // Only s2 and s3 are compared; s1 may be metastable
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1      <= RST_VAL;
      s2      <= RST_VAL;
      s3      <= RST_VAL;
      level_o <= RST_VAL;
      rise_o  <= 1'b0;
    end else begin
      s1      <= async_i;
      s2      <= s1;
      s3      <= s2;
      rise_o  <= 1'b0;
      if (s2 == s3) begin
        level_o <= s3;
        rise_o  <= s3 & ~level_o;
      end
    end
  end
endmodule

/* verilog/scpm_top.v */
// Synchronous clock divider, clock gates, reset collector and failure detector of the power manager
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "scpm_defs.vh"
// Overview of operation
// - One shared 8-bit prescaler feeds all clocks
// - CPU clock equals main over two-power divide
// - Each peripheral bus has own divide select
// - Bus root follows CPU, runs when CPU stops
// - Peripheral roots synchronous, divisible, run when halted
// - Separate gate for every module clock
// - Divide writes apply together, others unchanged
// - Ready flag low until new setting applies
// - Interrupt when setting applies if enabled
// - Power-on: cause recorded, source started, active
// - Reset defaults every divide to one
// - Manager always enabled, cleared by every device reset incl. software
// - Masked manager clock returns only at reset
// - Write protection except flags and cause
// - Debugger writes bypass protection
// - Debug keeps manager and all clocks but the CPU running
// - Collect reset sources, reset device, record
// - Power-on detector holds system in reset
// - Sleep gates domains, wake returns active
// - Main clock failure switches to safe oscillator
// - Failure when no main edge per slow period while active
// - Failure sets flag and backup bit; zero reverts
module scpm_top #(
  parameter MW         = 8,
  parameter MASK_A_RST = 8'hff,
  parameter MASK_B_RST = 8'h0f,
  parameter MASK_C_RST = 8'h00,
  parameter MASK_H_RST = 8'hff
) (
  input  wire                    clk_i,
  input  wire                    rst_n_i,
  input  wire [`SCPM_ADDR_W-1:0] addr_i,
  input  wire [31:0]             wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [31:0]             rdata_o,
  input  wire                    protect_i,
  input  wire                    dbg_access_i,
  input  wire                    dbg_active_i,
  input  wire                    main_clk_i,
  input  wire                    safe_osc_i,
  input  wire                    slow_ref_i,
  input  wire                    main_ready_i,
  input  wire                    por_i,
  input  wire                    core_brownout_detect_i,
  input  wire                    io_brownout_detect_i,
  input  wire                    ext_rst_n_i,
  input  wire                    wdt_rst_i,
  input  wire                    sw_rst_i,
  input  wire                    sleep_req_i,
  input  wire                    sleep_deep_i,
  input  wire                    wake_i,
  output reg                     cpu_clk_en_o,
  output reg                     ahb_clk_en_o,
  output reg  [MW-1:0]           ahb_mod_clk_en_o,
  output reg  [2:0]              apb_root_clk_en_o,
  output reg  [MW-1:0]           apba_mod_clk_en_o,
  output reg  [MW-1:0]           apbb_mod_clk_en_o,
  output reg  [MW-1:0]           apbc_mod_clk_en_o,
  output reg                     main_src_en_o,
  output reg                     backup_clock_status_o,
  output reg                     dev_rst_o,
  output reg                     sleeping_o,
  output wire                    irq_o
);
  localparam ST_ACTIVE  = 3'h0;
  localparam ST_IDLE0   = 3'h1;
  localparam ST_IDLE1   = 3'h2;
  localparam ST_IDLE2   = 3'h3;
  localparam ST_STANDBY = 3'h4;

  // Divide tap: ticks when the low div bits of the prescaler are zero
  function tap;
    input [7:0] cnt;
    input [2:0] div;
    begin
      tap = ((cnt & ~(8'hff << div)) == 8'h00);
    end
  endfunction

  wire main_rise;
  wire safe_rise;
  wire ref_rise;
  wire ext_lvl;

  scpm_sync #(.RST_VAL(1'b0)) u_main (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (main_clk_i),
    .level_o (),
    .rise_o  (main_rise)
  );
  scpm_sync #(.RST_VAL(1'b0)) u_safe (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (safe_osc_i),
    .level_o (),
    .rise_o  (safe_rise)
  );
  scpm_sync #(.RST_VAL(1'b0)) u_ref (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (slow_ref_i),
    .level_o (),
    .rise_o  (ref_rise)
  );
  scpm_sync #(.RST_VAL(1'b1)) u_ext (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (ext_rst_n_i),
    .level_o (ext_lvl),
    .rise_o  ()
  );

  reg  [7:0]    pre_cnt;
  reg  [2:0]    cpu_div;
  reg  [2:0]    cpu_div_new;
  reg  [8:0]    apb_div;
  reg  [8:0]    apb_div_new;
  reg           pend;
  reg           rdy_flag;
  reg           cfd_flag;
  reg  [1:0]    irq_en;
  reg           cfden;
  reg  [1:0]    sleep_lvl;
  reg  [MW-1:0] mask_a;
  reg  [MW-1:0] mask_b;
  reg  [MW-1:0] mask_c;
  reg  [MW-1:0] mask_h;
  reg  [7:0]    reset_cause_reg;
  reg  [2:0]    state;
  reg  [2:0]    next_state;
  reg           seen_edge;

  wire       src_tick = backup_clock_status_o ? safe_rise : main_rise;
  wire       boundary = src_tick & (pre_cnt[6:0] == `SCPM_PRE_BOUND);
  wire       apply    = pend & boundary;
  wire       bus_on   = mask_a[`SCPM_PM_MASK_BIT];
  wire       wr_any   = wr_i & bus_on;
  wire       wr_prot  = wr_any & (~protect_i | dbg_access_i);
  wire [7:0] rst_src  = {1'b0, sw_rst_i, wdt_rst_i, ~ext_lvl, 1'b0,
                         io_brownout_detect_i, core_brownout_detect_i, por_i};
  wire       any_rst  = |rst_src;
  wire       cfd_fail = ref_rise & cfden & ~seen_edge & (state == ST_ACTIVE);
  wire       sel_wr   = wr_prot & ((addr_i == `SCPM_OFF_CPU_CLOCK_SELECT_REG) | (addr_i == `SCPM_OFF_APBASEL) |
                                   (addr_i == `SCPM_OFF_APBBSEL) | (addr_i == `SCPM_OFF_APBCSEL));
  wire       w1c_flag = wr_any & (addr_i == `SCPM_OFF_IRQ_FLAG_REG);

  assign irq_o = (rdy_flag & irq_en[`SCPM_INT_RDY]) | (cfd_flag & irq_en[`SCPM_INT_CFD]);

  // Device reset follows every source; the por source keeps it asserted
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      dev_rst_o     <= 1'b1;
      main_src_en_o <= 1'b0;
      reset_cause_reg        <= `SCPM_RC_RST;
    end else begin
      dev_rst_o     <= any_rst;
      main_src_en_o <= 1'b1;
      if (any_rst) begin
        reset_cause_reg <= rst_src;
      end else if (wr_any & (addr_i == `SCPM_OFF_RESET_CAUSE_REG)) begin
        reset_cause_reg <= reset_cause_reg & ~wdata_i[7:0];
      end
    end
  end

  // Prescaler has no enable of its own; the block can never be switched off
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_cnt <= 8'h00;
    end else if (src_tick) begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // Configuration; cleared by power-on and by every device reset
  always @(posedge clk_i) begin
    if (!rst_n_i || dev_rst_o) begin
      cpu_div     <= `SCPM_DIV_RST;
      cpu_div_new <= `SCPM_DIV_RST;
      apb_div     <= {3{`SCPM_DIV_RST}};
      apb_div_new <= {3{`SCPM_DIV_RST}};
      pend        <= 1'b0;
      irq_en      <= 2'h0;
      cfden       <= 1'b0;
      sleep_lvl   <= 2'h0;
      mask_a      <= MASK_A_RST[MW-1:0];
      mask_b      <= MASK_B_RST[MW-1:0];
      mask_c      <= MASK_C_RST[MW-1:0];
      mask_h      <= MASK_H_RST[MW-1:0];
    end else begin
      if (apply) begin
        cpu_div <= cpu_div_new;
        apb_div <= apb_div_new;
        pend    <= 1'b0;
      end
      if (sel_wr) begin
        pend <= 1'b1;
      end
      if (wr_prot) begin
        case (addr_i)
          `SCPM_OFF_CTRL:     cfden <= wdata_i[`SCPM_CTRL_CFDEN];
          `SCPM_OFF_SLEEP:    sleep_lvl <= wdata_i[1:0];
          `SCPM_OFF_CPU_CLOCK_SELECT_REG:   cpu_div_new <= wdata_i[2:0];
          `SCPM_OFF_APBASEL:  apb_div_new[2:0] <= wdata_i[2:0];
          `SCPM_OFF_APBBSEL:  apb_div_new[5:3] <= wdata_i[2:0];
          `SCPM_OFF_APBCSEL:  apb_div_new[8:6] <= wdata_i[2:0];
          `SCPM_OFF_APBAMASK: mask_a <= wdata_i[MW-1:0];
          `SCPM_OFF_APBBMASK: mask_b <= wdata_i[MW-1:0];
          `SCPM_OFF_APBCMASK: mask_c <= wdata_i[MW-1:0];
          `SCPM_OFF_AHBMASK:  mask_h <= wdata_i[MW-1:0];
          `SCPM_OFF_INTENCLR: irq_en <= irq_en & ~wdata_i[1:0];
          `SCPM_OFF_IRQ_ENABLE_SET: irq_en <= irq_en | wdata_i[1:0];
          default:            irq_en <= irq_en;
        endcase
      end
    end
  end

  // Flags: a hardware set beats a clear in the same cycle
  always @(posedge clk_i) begin
    if (!rst_n_i || dev_rst_o) begin
      rdy_flag              <= 1'b1;
      cfd_flag              <= 1'b0;
      backup_clock_status_o <= 1'b0;
      seen_edge             <= 1'b0;
    end else begin
      if (apply) begin
        rdy_flag <= 1'b1;
      end else if (sel_wr) begin
        rdy_flag <= 1'b0;
      end else if (w1c_flag & wdata_i[`SCPM_INT_RDY]) begin
        rdy_flag <= 1'b0;
      end
      if (cfd_fail) begin
        cfd_flag <= 1'b1;
      end else if (w1c_flag & wdata_i[`SCPM_INT_CFD]) begin
        cfd_flag <= 1'b0;
      end
      if (cfd_fail) begin
        backup_clock_status_o <= 1'b1;
      end else if (wr_prot & (addr_i == `SCPM_OFF_CTRL) & ~wdata_i[`SCPM_CTRL_BKUP]) begin
        backup_clock_status_o <= 1'b0;
      end
      // Window restarts at each rising slow reference edge
      if (ref_rise) begin
        seen_edge <= main_rise;
      end else if (main_rise) begin
        seen_edge <= 1'b1;
      end
    end
  end

  // Sleep controller
  always @* begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (sleep_req_i) begin
          if (sleep_deep_i) begin
            next_state = ST_STANDBY;
          end else begin
            case (sleep_lvl)
              2'h0:    next_state = ST_IDLE0;
              2'h1:    next_state = ST_IDLE1;
              default: next_state = ST_IDLE2;
            endcase
          end
        end
      end
      ST_IDLE0, ST_IDLE1, ST_IDLE2, ST_STANDBY: begin
        if (wake_i) begin
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i || dev_rst_o) begin
      state <= ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // Clock enables; debug keeps every generated clock but the processor running
  wire       cpu_tick = src_tick & tap(pre_cnt, cpu_div);
  wire       run      = ~dev_rst_o & main_ready_i;
  wire       ahb_on   = run & (dbg_active_i | (state == ST_ACTIVE) | (state == ST_IDLE0));
  wire       apb_on   = run & (dbg_active_i | (state != ST_IDLE2) & (state != ST_STANDBY));
  wire [2:0] apb_tick = {src_tick & tap(pre_cnt, apb_div[8:6]),
                         src_tick & tap(pre_cnt, apb_div[5:3]),
                         src_tick & tap(pre_cnt, apb_div[2:0])};

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cpu_clk_en_o      <= 1'b0;
      ahb_clk_en_o      <= 1'b0;
      ahb_mod_clk_en_o  <= {MW{1'b0}};
      apb_root_clk_en_o <= 3'h0;
      apba_mod_clk_en_o <= {MW{1'b0}};
      apbb_mod_clk_en_o <= {MW{1'b0}};
      apbc_mod_clk_en_o <= {MW{1'b0}};
      sleeping_o        <= 1'b0;
    end else begin
      cpu_clk_en_o      <= cpu_tick & run & (state == ST_ACTIVE);
      ahb_clk_en_o      <= cpu_tick & ahb_on;
      ahb_mod_clk_en_o  <= {MW{cpu_tick & ahb_on}} & mask_h;
      apb_root_clk_en_o <= apb_tick & {3{apb_on}};
      apba_mod_clk_en_o <= {MW{apb_tick[0] & apb_on}} & mask_a;
      apbb_mod_clk_en_o <= {MW{apb_tick[1] & apb_on}} & mask_b;
      apbc_mod_clk_en_o <= {MW{apb_tick[2] & apb_on}} & mask_c;
      sleeping_o        <= (state != ST_ACTIVE);
    end
  end

  // Read port; a masked manager bus clock reads as zero
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= 32'h00000000;
      if (rd_i & bus_on) begin
        case (addr_i)
          `SCPM_OFF_CTRL:     rdata_o <= {27'h0, backup_clock_status_o, 3'h0, cfden};
          `SCPM_OFF_SLEEP:    rdata_o <= {30'h0, sleep_lvl};
          `SCPM_OFF_CPU_CLOCK_SELECT_REG:   rdata_o <= {29'h0, cpu_div_new};
          `SCPM_OFF_APBASEL:  rdata_o <= {29'h0, apb_div_new[2:0]};
          `SCPM_OFF_APBBSEL:  rdata_o <= {29'h0, apb_div_new[5:3]};
          `SCPM_OFF_APBCSEL:  rdata_o <= {29'h0, apb_div_new[8:6]};
          `SCPM_OFF_APBAMASK: rdata_o[MW-1:0] <= mask_a;
          `SCPM_OFF_APBBMASK: rdata_o[MW-1:0] <= mask_b;
          `SCPM_OFF_APBCMASK: rdata_o[MW-1:0] <= mask_c;
          `SCPM_OFF_AHBMASK:  rdata_o[MW-1:0] <= mask_h;
          `SCPM_OFF_INTENCLR: rdata_o <= {30'h0, irq_en};
          `SCPM_OFF_IRQ_ENABLE_SET: rdata_o <= {30'h0, irq_en};
          `SCPM_OFF_IRQ_FLAG_REG:  rdata_o <= {30'h0, cfd_flag, rdy_flag};
          `SCPM_OFF_RESET_CAUSE_REG:   rdata_o <= {24'h0, reset_cause_reg};
          default:            rdata_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

/* testbench/scpm_top_properties.sv */
// Port-level properties of the clock and power manager
`timescale 1ns/1ps
module scpm_top_checker #(
  parameter MW = 8
) (
  input wire logic          clk_i,
  input wire logic          rst_n_i,
  input wire logic          por_i,
  input wire logic          wdt_rst_i,
  input wire logic          sw_rst_i,
  input wire logic          main_ready_i,
  input wire logic          wake_i,
  input wire logic          cpu_clk_en_o,
  input wire logic          ahb_clk_en_o,
  input wire logic [MW-1:0] ahb_mod_clk_en_o,
  input wire logic [2:0]    apb_root_clk_en_o,
  input wire logic [MW-1:0] apba_mod_clk_en_o,
  input wire logic          main_src_en_o,
  input wire logic          dev_rst_o,
  input wire logic          sleeping_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_AHB_WITH_CPU: assert property (cpu_clk_en_o |-> ahb_clk_en_o)
    else $error("cpu tick without bus tick");
  AST_AHB_MOD_GATE: assert property (|ahb_mod_clk_en_o |-> ahb_clk_en_o)
    else $error("module tick without bus root tick");
  AST_APBA_MOD_GATE: assert property (|apba_mod_clk_en_o |-> apb_root_clk_en_o[0])
    else $error("bus A module tick without root tick");
  // Reset must act even though every other check is disabled by it
  AST_RESET_HOLDS: assert property (disable iff (1'b0) !rst_n_i |=> dev_rst_o && !main_src_en_o)
    else $error("device not held in reset");
  AST_SOURCE_RESET: assert property ((por_i || wdt_rst_i || sw_rst_i) |=> dev_rst_o)
    else $error("reset source not turned into device reset");
  AST_NO_CPU_ASLEEP: assert property (sleeping_o && $past(sleeping_o) && !$past(wake_i) && !$past(wake_i, 2)
    |-> !cpu_clk_en_o)
    else $error("cpu tick while asleep");
  AST_WAKE_EXIT: assert property (sleeping_o && wake_i |-> ##[1:2] !sleeping_o)
    else $error("wake did not return to active");
  AST_SOURCE_STARTS: assert property ($rose(rst_n_i) |-> ##[0:2] main_src_en_o)
    else $error("main source not started");
  AST_CLOCKS_WAIT_SOURCE: assert property (!main_ready_i && !$past(main_ready_i) |-> !cpu_clk_en_o)
    else $error("cpu tick before main source ready");
  AST_TICK_SINGLE: assert property (cpu_clk_en_o |=> !cpu_clk_en_o)
    else $error("cpu tick longer than one cycle");
  cover property (sleeping_o && ahb_clk_en_o);
  cover property ($rose(dev_rst_o));
  cover property (cpu_clk_en_o && apb_root_clk_en_o[1]);
endmodule

bind scpm_top scpm_top_checker #(.MW(MW)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .por_i(por_i), .wdt_rst_i(wdt_rst_i), .sw_rst_i(sw_rst_i),
  .main_ready_i(main_ready_i), .wake_i(wake_i), .cpu_clk_en_o(cpu_clk_en_o), .ahb_clk_en_o(ahb_clk_en_o),
  .ahb_mod_clk_en_o(ahb_mod_clk_en_o), .apb_root_clk_en_o(apb_root_clk_en_o),
  .apba_mod_clk_en_o(apba_mod_clk_en_o), .main_src_en_o(main_src_en_o), .dev_rst_o(dev_rst_o),
  .sleeping_o(sleeping_o));

/* testbench/scpm_osc_model.sv */
// Main, safe and slow reference oscillators feeding the manager's clock pins
`timescale 1ns/1ps
module scpm_osc_model #(
  parameter MAIN_HALF = 20,
  parameter SAFE_HALF = 30,
  parameter REF_HALF  = 200
) (
  input  wire logic run_i,
  output logic      main_clk_o,
  output logic      safe_osc_o,
  output logic      slow_ref_o
);
  initial begin
    main_clk_o = 1'h0;
    safe_osc_o = 1'h0;
    slow_ref_o = 1'h0;
    // Offset keeps every pin edge away from the system clock edges
    #3;
    fork
      forever #SAFE_HALF safe_osc_o = !safe_osc_o;
      forever #REF_HALF slow_ref_o = !slow_ref_o;
      // A failed crystal stands still low
      forever #MAIN_HALF main_clk_o = run_i ? !main_clk_o : 1'h0;
    join
  end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the clock and power manager
`timescale 1ns/1ps
`include "scpm_defs.vh"
module tb_top;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} scpm_row_t;
  logic        clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, prot = 1'h0, dbg = 1'h0;
  logic        mrdy = 1'h0, slp = 1'h0, wake = 1'h0, run = 1'h1;
  logic        dbga = 1'h0, deep = 1'h0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0, d;
  logic [6:0]  src = 7'h0;
  logic [31:0] rdata;
  logic [7:0]  ahbm, apba, apbb;
  logic [2:0]  root;
  logic        cpu, ahb, msrc, bkup, drst, sleeping, irq, mclk, sosc, sref;
  logic [5:0]  t;
  int          bad_count = 0, tests_run = 0, cycles = 0, n [6];
  scpm_row_t   rows [10] = '{
    '{1'h0, `SCPM_OFF_CPU_CLOCK_SELECT_REG, 32'h0, 32'h0},
    '{1'h0, `SCPM_OFF_APBAMASK, 32'h0, 32'hff},
    '{1'h0, `SCPM_OFF_APBBMASK, 32'h0, 32'h0f},
    '{1'h0, `SCPM_OFF_RESET_CAUSE_REG, 32'h0, 32'h1},
    '{1'h0, `SCPM_OFF_IRQ_FLAG_REG, 32'h0, 32'h1},
    '{1'h0, 8'h3c, 32'h0, 32'h0},
    '{1'h1, `SCPM_OFF_APBASEL, 32'h2, 32'h2},
    '{1'h1, `SCPM_OFF_APBBSEL, 32'h3, 32'h3},
    '{1'h1, `SCPM_OFF_APBBMASK, 32'h55, 32'h55},
    '{1'h1, `SCPM_OFF_SLEEP, 32'h0, 32'h0}};
  assign t = {apbb[1], apbb[0], root[1], root[0], ahb, cpu};

  scpm_osc_model osc (.run_i(run), .main_clk_o(mclk), .safe_osc_o(sosc), .slow_ref_o(sref));
  scpm_top dut (
    .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .protect_i(prot), .dbg_access_i(dbg), .dbg_active_i(dbga), .main_clk_i(mclk), .safe_osc_i(sosc),
    .slow_ref_i(sref), .main_ready_i(mrdy), .por_i(src[0]), .core_brownout_detect_i(src[1]),
    .io_brownout_detect_i(src[2]), .ext_rst_n_i(!src[4]), .wdt_rst_i(src[5]), .sw_rst_i(src[6]),
    .sleep_req_i(slp), .sleep_deep_i(deep), .wake_i(wake), .cpu_clk_en_o(cpu), .ahb_clk_en_o(ahb),
    .ahb_mod_clk_en_o(ahbm), .apb_root_clk_en_o(root), .apba_mod_clk_en_o(apba), .apbb_mod_clk_en_o(apbb),
    .apbc_mod_clk_en_o(), .main_src_en_o(msrc), .backup_clock_status_o(bkup), .dev_rst_o(drst),
    .sleeping_o(sleeping), .irq_o(irq));

  initial forever #5 clk = !clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask

  // Window of 256 cycles is a whole number of every divided period
  task automatic check_n(input int e [6]);
    n = '{default: 0};
    repeat (256) begin
      @(negedge clk);
      for (int i = 0; i < 6; i++) n[i] += t[i];
    end
    for (int i = 0; i < 6; i++) check(n[i], e[i]);
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'h1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    #1;
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 check(drst, 1'h1);
    check(msrc, 1'h0);
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    #1 check(msrc, 1'h1);
    mrdy <= 1'h1;
    repeat (6) @(posedge clk);
    check_n('{64, 64, 64, 64, 64, 64});
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a);
      check(d, rows[i].e);
    end
    $display("test reset and table finished");
    wr_reg(`SCPM_OFF_IRQ_ENABLE_SET, 32'h1);
    wait_irq();
    wr_reg(`SCPM_OFF_IRQ_FLAG_REG, 32'h1);
    check(irq, 1'h0);
    wr_reg(`SCPM_OFF_CPU_CLOCK_SELECT_REG, 32'h2);
    rd_reg(`SCPM_OFF_IRQ_FLAG_REG);
    check(d, 32'h0);
    wait_irq();
    check(irq, 1'h1);
    check_n('{16, 16, 16, 8, 8, 0});
    $display("test divide finished");
    slp <= 1'h1;
    @(posedge clk);
    slp <= 1'h0;
    repeat (4) @(posedge clk);
    #1 check(sleeping, 1'h1);
    check_n('{0, 16, 16, 8, 8, 0});
    wake <= 1'h1;
    repeat (3) @(posedge clk);
    wake <= 1'h0;
    #1 check(sleeping, 1'h0);
    // Deepest idle level stops every bus root unless a debugger is attached
    wr_reg(`SCPM_OFF_SLEEP, 32'h2);
    slp <= 1'h1;
    @(posedge clk);
    slp <= 1'h0;
    repeat (4) @(posedge clk);
    check_n('{0, 0, 0, 0, 0, 0});
    dbga <= 1'h1;
    check_n('{0, 16, 16, 8, 8, 0});
    dbga <= 1'h0;
    wake <= 1'h1;
    repeat (3) @(posedge clk);
    wake <= 1'h0;
    #1 check(sleeping, 1'h0);
    @(posedge clk);
    deep <= 1'h1;
    slp <= 1'h1;
    @(posedge clk);
    slp <= 1'h0;
    deep <= 1'h0;
    repeat (4) @(posedge clk);
    #1 check(sleeping, 1'h1);
    check_n('{0, 0, 0, 0, 0, 0});
    wake <= 1'h1;
    repeat (3) @(posedge clk);
    wake <= 1'h0;
    #1 check(sleeping, 1'h0);
    $display("test sleep finished");
    prot <= 1'h1;
    wr_reg(`SCPM_OFF_APBCMASK, 32'h0f);
    rd_reg(`SCPM_OFF_APBCMASK);
    check(d, 32'h0);
    dbg <= 1'h1;
    wr_reg(`SCPM_OFF_APBCMASK, 32'h0f);
    rd_reg(`SCPM_OFF_APBCMASK);
    check(d, 32'h0f);
    dbg <= 1'h0;
    wr_reg(`SCPM_OFF_RESET_CAUSE_REG, 32'h1);
    rd_reg(`SCPM_OFF_RESET_CAUSE_REG);
    check(d, 32'h0);
    prot <= 1'h0;
    $display("test protection finished");
    wr_reg(`SCPM_OFF_APBAMASK, 32'hfd);
    wr_reg(`SCPM_OFF_APBAMASK, 32'hff);
    rd_reg(`SCPM_OFF_APBAMASK);
    check(d, 32'h0);
    for (int b = 0; b < 7; b++) begin
      if (b == 3) continue;
      src <= 7'h1 << b;
      repeat (6) @(posedge clk);
      src <= 7'h0;
      repeat (10) @(posedge clk);
      rd_reg(`SCPM_OFF_RESET_CAUSE_REG);
      check(d, 32'h1 << b);
    end
    rd_reg(`SCPM_OFF_APBAMASK);
    check(d, 32'hff);
    rd_reg(`SCPM_OFF_CPU_CLOCK_SELECT_REG);
    check(d, 32'h0);
    $display("test reset sources finished");
    wr_reg(`SCPM_OFF_CTRL, 32'h1);
    wr_reg(`SCPM_OFF_IRQ_ENABLE_SET, 32'h2);
    run <= 1'h0;
    wait_irq();
    check(bkup, 1'h1);
    rd_reg(`SCPM_OFF_IRQ_FLAG_REG);
    check(d & 32'h2, 32'h2);
    rd_reg(`SCPM_OFF_CTRL);
    check(d, 32'h11);
    run <= 1'h1;
    repeat (100) @(posedge clk);
    wr_reg(`SCPM_OFF_CTRL, 32'h1);
    check(bkup, 1'h0);
    $display("test clock failure finished");
    summarize();
  end
endmodule
